/* File: verilog/mac_pkg.sv */
package mac_pkg;

  // ===========================================================================
  // Widths
  localparam int unsigned OPW  = 16;
  localparam int unsigned MULW = 17;
  localparam int unsigned PRDW = 33;
  localparam int unsigned ACCW = 40;
  localparam int unsigned GLO  = 32;
  localparam int unsigned GHI  = 39;
  localparam int unsigned B31  = 31;
  localparam int unsigned SHW  = 5;

  // ===========================================================================
  // Register map of the plain register port
  localparam logic [3:0] REG_CORE_CTRL  = 4'h0;
  localparam logic [3:0] REG_TRAP_CTRL  = 4'h1;
  localparam logic [3:0] REG_STATUS     = 4'h2;
  localparam logic [3:0] REG_ACCA_LO    = 4'h3;
  localparam logic [3:0] REG_ACCA_HI    = 4'h4;
  localparam logic [3:0] REG_ACCB_LO    = 4'h5;
  localparam logic [3:0] REG_ACCB_HI    = 4'h6;
  localparam logic [3:0] REG_IRQ_STAT   = 4'h7;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h8;

  // Field positions in core_control_reg.
  localparam int unsigned CC_CLIP_A   = 7;
  localparam int unsigned CC_CLIP_B   = 6;
  localparam int unsigned CC_CLIP_WID = 4;
  localparam int unsigned CC_FRAC     = 0;
  // Field positions in trap_control_reg.
  localparam int unsigned TC_OVA = 10;
  localparam int unsigned TC_OVB = 9;
  // Status bit positions.
  localparam int unsigned ST_OA  = 0;
  localparam int unsigned ST_OB  = 1;
  localparam int unsigned ST_SA  = 2;
  localparam int unsigned ST_SB  = 3;
  localparam int unsigned ST_OAB = 4;
  localparam int unsigned ST_SAB = 5;

  localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
  localparam logic [15:0] TRAP_CTRL_RST = 16'h0000;
  localparam logic [3:0]  IRQ_RST       = 4'h0;

  // ===========================================================================
  // Operations
  typedef enum logic [2:0] {
    MAC_NOP  = 3'h0,
    MAC_MPY  = 3'h1,
    MAC_MAC  = 3'h3,
    MAC_MSC  = 3'h2,
    MAC_ADD  = 3'h6,
    MAC_LOAD = 3'h7,
    MAC_IMUL = 3'h5
  } mac_op_t;

  typedef struct packed {
    mac_op_t          op;
    logic             acc_sel;
    logic             sgn_a;
    logic             sgn_b;
    logic             byte_mode;
    logic [OPW-1:0]   opa;
    logic [OPW-1:0]   opb;
    logic [ACCW-1:0]  add_data;
    logic             shift_en;
    logic             shift_left;
    logic [SHW-1:0]   shift_amt;
  } mac_cmd_t;

  typedef struct packed {
    logic             valid;
    logic [2*OPW-1:0] data;
    logic             wide;
  } mac_wres_t;

  typedef struct packed {
    logic [ACCW-1:0] acc_a;
    logic [ACCW-1:0] acc_b;
    logic            oa;
    logic            ob;
    logic            sa;
    logic            sb;
    logic [15:0]     core_ctrl;
    logic [15:0]     trap_ctrl;
    logic [3:0]      irq_stat;
    logic [3:0]      irq_mask;
    logic [15:0]     rdata;
    mac_wres_t       wres;
    logic            trap;
    logic            irq;
  } mac_state_t;

endpackage

/* File: verilog/mac_datapath.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - 17x17 signed/unsigned multiply, fractional or integer scaling.
// - Operands widened by zero or sign extension.
// - 33-bit product sign-extended to 40 bits.
// - Fractional mode gives a 1.31 product.
// - Same multiplier serves integer mixed-sign multiplies.
// - Byte operands give 16-bit, word give 32-bit.
// - 40-bit adder, accumulator A or B source/destination.
// - Add and load data optionally barrel shifted.
// - Adder has zero input and true/complement input.
// - Add uses carry low; subtract complements, borrow low.
// - Overflow from bit 39 detected as catastrophic.
// - Guard bits unequal flags recoverable overflow.
// - Saturation from result, flags, clip enables, width.
// - Guard-overflow flag updated on every adder pass.
// - Clip flag set on bit 31 or 39 saturation.
// - Combined flags are OR of both accumulators.
// - Guard overflow with trap enable raises warning trap.
// - Flags latched and shown in status register.
module mac_datapath
  import mac_pkg::*;
(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Instruction command.
  input  wire logic             cmd_valid,
  input  wire mac_cmd_t         cmd,
  // Register port.
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // Results.
  output mac_wres_t             wreg_result,
  output logic      [ACCW-1:0]  acc_a_out,
  output logic      [ACCW-1:0]  acc_b_out,
  output logic      [5:0]       status_flags,
  output logic                  arith_trap,
  output logic                  irq
);

  mac_state_t s_q;
  mac_state_t s_d;

  // ===========================================================================
  // Multiplier
  logic signed [MULW-1:0]   ma;
  logic signed [MULW-1:0]   mb;
  logic signed [2*MULW-1:0] mprod;
  logic        [PRDW-1:0]   mscaled;
  logic        [ACCW-1:0]   mext;
  logic                     frac_mode;

  assign frac_mode = s_q.core_ctrl[CC_FRAC];
  assign ma    = {cmd.sgn_a & cmd.opa[OPW-1], cmd.opa};
  assign mb    = {cmd.sgn_b & cmd.opb[OPW-1], cmd.opb};
  assign mprod = ma * mb;
  // Fractional scaling shifts left one place so the radix follows the sign.
  assign mscaled = frac_mode && cmd.op != MAC_IMUL ? {mprod[PRDW-2:0], 1'b0}
                                                  : mprod[PRDW-1:0];
  assign mext = {{(ACCW-PRDW){mscaled[PRDW-1]}}, mscaled};

  // ===========================================================================
  // Barrel shifter for add and load data
  logic [ACCW-1:0] shdata;

  always_comb begin
    shdata = cmd.add_data;
    if (cmd.shift_en) begin
      if (cmd.shift_left) begin
        shdata = cmd.add_data << cmd.shift_amt;
      end else begin
        shdata = ACCW'($signed(cmd.add_data) >>> cmd.shift_amt);
      end
    end
  end

  // ===========================================================================
  // Adder / subtracter
  logic [ACCW-1:0] src_acc;
  logic [ACCW-1:0] in_x;
  logic [ACCW-1:0] in_y;
  logic            sub;
  logic            zero_x;
  logic [ACCW:0]   sum;
  logic [ACCW-1:0] res;
  logic            ovf39;
  logic            ovf31;
  logic            guard_ovf;
  logic            clip_en;
  logic            clip_wide;
  logic            do_clip;
  logic            true_neg;
  logic [ACCW-1:0] clip_val;
  logic [ACCW-1:0] final_res;
  logic            uses_adder;

  assign src_acc = cmd.acc_sel ? s_q.acc_b : s_q.acc_a;
  assign sub     = cmd.op == MAC_MSC;
  assign zero_x  = cmd.op == MAC_MPY || cmd.op == MAC_LOAD;
  assign in_x    = zero_x ? '0 : src_acc;
  always_comb begin
    in_y = mext;
    if (cmd.op == MAC_ADD || cmd.op == MAC_LOAD) begin
      in_y = shdata;
    end
    if (sub) begin
      in_y = ~mext;
    end
  end
  // Carry-in is one for subtract so that complement plus one negates.
  assign sum = {1'b0, in_x} + {1'b0, in_y} + {{ACCW{1'b0}}, sub};
  assign res = sum[ACCW-1:0];
  assign ovf39 = (in_x[GHI] == in_y[GHI]) && (res[GHI] != in_x[GHI]);
  assign guard_ovf = ~((&res[GHI:GLO]) | ~(|res[GHI:GLO]));
  // Bit 31 overflow: the upper nine bits no longer agree with the 32-bit sign.
  assign ovf31 = ~((&res[GHI:B31]) | ~(|res[GHI:B31]));
  assign true_neg = ovf39 ? in_x[GHI] : res[GHI];
  assign clip_en = cmd.acc_sel ? s_q.core_ctrl[CC_CLIP_B] : s_q.core_ctrl[CC_CLIP_A];
  assign clip_wide = s_q.core_ctrl[CC_CLIP_WID];
  assign do_clip = clip_en && (clip_wide ? ovf39 : (ovf31 || ovf39));
  always_comb begin
    if (clip_wide) begin
      clip_val = true_neg ? {1'b1, {(ACCW-1){1'b0}}} : {1'b0, {(ACCW-1){1'b1}}};
    end else begin
      clip_val = true_neg ? {{(ACCW-B31){1'b1}}, {B31{1'b0}}}
                          : {{(ACCW-B31){1'b0}}, {B31{1'b1}}};
    end
  end
  assign final_res = do_clip ? clip_val : res;
  assign uses_adder = cmd_valid && cmd.op != MAC_NOP && cmd.op != MAC_IMUL;

  // ===========================================================================
  // Next state
  logic [3:0] ev;
  logic       oa_n;
  logic       ob_n;

  always_comb begin
    s_d = s_q;
    s_d.wres.valid = 1'b0;
    ev = '0;
    oa_n = s_q.oa;
    ob_n = s_q.ob;
    if (uses_adder) begin
      if (cmd.acc_sel) begin
        s_d.acc_b = final_res;
        ob_n = guard_ovf && !do_clip;
        s_d.sb = s_q.sb | do_clip;
        ev[1] = ob_n;
        ev[3] = do_clip;
      end else begin
        s_d.acc_a = final_res;
        oa_n = guard_ovf && !do_clip;
        s_d.sa = s_q.sa | do_clip;
        ev[0] = oa_n;
        ev[2] = do_clip;
      end
    end
    s_d.oa = oa_n;
    s_d.ob = ob_n;
    if (cmd_valid && cmd.op == MAC_IMUL) begin
      s_d.wres.valid = 1'b1;
      s_d.wres.wide  = !cmd.byte_mode;
      s_d.wres.data  = cmd.byte_mode ? {16'h0000, mprod[15:0]} : mprod[31:0];
    end
    s_d.trap = (oa_n & s_q.trap_ctrl[TC_OVA]) | (ob_n & s_q.trap_ctrl[TC_OVB]);
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CORE_CTRL: s_d.rdata = s_q.core_ctrl;
        REG_TRAP_CTRL: s_d.rdata = s_q.trap_ctrl;
        REG_STATUS:    s_d.rdata = {10'h000, s_q.sa | s_q.sb, s_q.oa | s_q.ob,
                                    s_q.sb, s_q.sa, s_q.ob, s_q.oa};
        REG_ACCA_LO:   s_d.rdata = s_q.acc_a[15:0];
        REG_ACCA_HI:   s_d.rdata = s_q.acc_a[31:16];
        REG_ACCB_LO:   s_d.rdata = s_q.acc_b[15:0];
        REG_ACCB_HI:   s_d.rdata = s_q.acc_b[31:16];
        REG_IRQ_STAT:  s_d.rdata = {12'h000, s_q.irq_stat};
        REG_IRQ_MASK:  s_d.rdata = {12'h000, s_q.irq_mask};
        default:       s_d.rdata = 16'h0000;
      endcase
    end
    s_d.irq_stat = s_q.irq_stat;
    if (reg_wr) begin
      case (reg_addr)
        REG_CORE_CTRL: s_d.core_ctrl = reg_wdata;
        REG_TRAP_CTRL: s_d.trap_ctrl = reg_wdata;
        REG_STATUS: begin
          // A flag raised by the adder in the same cycle survives the clear.
          s_d.oa = ev[0] | (oa_n & reg_wdata[ST_OA]);
          s_d.ob = ev[1] | (ob_n & reg_wdata[ST_OB]);
          s_d.sa = ev[2] | (s_q.sa & reg_wdata[ST_SA]);
          s_d.sb = ev[3] | (s_q.sb & reg_wdata[ST_SB]);
        end
        REG_IRQ_STAT:  s_d.irq_stat = s_q.irq_stat & ~reg_wdata[3:0];
        REG_IRQ_MASK:  s_d.irq_mask = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
    // Events set after the clear so a same-cycle event is kept.
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{acc_a: '0, acc_b: '0, oa: 1'b0, ob: 1'b0, sa: 1'b0, sb: 1'b0,
               core_ctrl: CORE_CTRL_RST, trap_ctrl: TRAP_CTRL_RST,
               irq_stat: IRQ_RST, irq_mask: IRQ_RST, rdata: 16'h0000,
               wres: '0, trap: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata    = s_q.rdata;
  assign wreg_result  = s_q.wres;
  assign acc_a_out    = s_q.acc_a;
  assign acc_b_out    = s_q.acc_b;
  assign status_flags = {s_q.sa | s_q.sb, s_q.oa | s_q.ob,
                         s_q.sb, s_q.sa, s_q.ob, s_q.oa};
  assign arith_trap   = s_q.trap;
  assign irq          = s_q.irq;

endmodule // mac_datapath

/* File: tb/mac_core_model.sv */
`timescale 1ns/100ps
// ====================
// Register file side: keeps the last product written back and counts writes.
module mac_core_model
  import mac_pkg::*;
(
  // Clock and reset.
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  // Write-back from the datapath.
  input  wire mac_wres_t wres,
  output logic [31:0]    wreg,
  output logic           wide,
  output logic [7:0]     n_wb
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wreg <= 32'h0000_0000;
      wide <= 1'b0;
      n_wb <= 8'h00;
    end else if (wres.valid) begin
      wreg <= wres.data;
      wide <= wres.wide;
      n_wb <= n_wb + 8'h01;
    end
  end
endmodule // mac_core_model

/* File: tb/mac_checker.sv */
`timescale 1ns/100ps
// ====================
// Port checks of the multiply and accumulate datapath.
module mac_checker
  import mac_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            cmd_valid,
  input wire mac_cmd_t        cmd,
  input wire logic [3:0]      reg_addr,
  input wire logic [15:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [15:0]     reg_rdata,
  input wire mac_wres_t       wreg_result,
  input wire logic [ACCW-1:0] acc_a_out,
  input wire logic [ACCW-1:0] acc_b_out,
  input wire logic [5:0]      status_flags,
  input wire logic            arith_trap,
  input wire logic            irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire imul = cmd_valid && cmd.op == MAC_IMUL;
  chk_oab_or: assert property (status_flags[4] == (status_flags[0] | status_flags[1]))
    else $error("combined guard flag wrong");
  chk_imul_pulse: assert property (imul |=> wreg_result.valid)
    else $error("product not written back");
  chk_wres_single: assert property (!imul |=> !wreg_result.valid)
    else $error("stray write-back");
  chk_byte_low: assert property (imul && cmd.byte_mode |=>
    !wreg_result.wide && wreg_result.data[31:16] == 16'h0000) else $error("byte result too wide");
  chk_prod_sext: assert property (cmd_valid && cmd.op == MAC_MPY && !cmd.acc_sel |=>
    acc_a_out[39:33] == {7{acc_a_out[32]}}) else $error("product not sign extended");
  chk_acc_hold: assert property (!cmd_valid && !reg_wr |=>
    $stable(acc_a_out) && $stable(acc_b_out)) else $error("accumulator moved while idle");
  chk_trap_cause: assert property ($rose(arith_trap) |-> status_flags[0] | status_flags[1])
    else $error("trap without guard overflow");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule // mac_checker

bind mac_datapath mac_checker mac_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd(cmd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wreg_result(wreg_result),
  .acc_a_out(acc_a_out), .acc_b_out(acc_b_out), .status_flags(status_flags),
  .arith_trap(arith_trap), .irq(irq));

/* File: tb/mac_datapath_tb.sv */
`timescale 1ns/100ps
// ====================
// Directed checks of the multiply and accumulate datapath.
module mac_datapath_tb
  import mac_pkg::*;
;
  logic            core_clk, rst_n, cmd_valid, reg_wr, reg_rd, sa, sb, bm, se;
  mac_cmd_t        cmd;
  logic [3:0]      reg_addr;
  logic [15:0]     reg_wdata, reg_rdata;
  mac_wres_t       wreg_result;
  logic [ACCW-1:0] acc_a_out, acc_b_out;
  logic [5:0]      status_flags;
  logic            arith_trap, irq, wide;
  logic [31:0]     wreg;
  logic [7:0]      n_wb;
  int              fail_count, n_tests;

  mac_datapath mac_datapath_inst (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wreg_result(wreg_result), .acc_a_out(acc_a_out),
    .acc_b_out(acc_b_out), .status_flags(status_flags), .arith_trap(arith_trap), .irq(irq));
  mac_core_model mac_core_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .wres(wreg_result), .wreg(wreg), .wide(wide), .n_wb(n_wb));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [79:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic run(input mac_op_t o, input logic s, input logic [15:0] a, b,
                     input logic [39:0] d);
    @(posedge core_clk);
    cmd <= '{op: o, acc_sel: s, sgn_a: sa, sgn_b: sb, byte_mode: bm, opa: a, opb: b,
             add_data: d, shift_en: se, shift_left: 1'b1, shift_amt: 5'h04};
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    {rst_n, cmd_valid, reg_wr, reg_rd, sa, sb, bm, se} = '0;
    cmd = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(REG_CORE_CTRL, 16'h0000);
    rd(REG_TRAP_CTRL, 16'h0000);
    rd(4'hF, 16'h0000);
    {sa, sb} = 2'h3;
    run(MAC_MPY, 1'b0, 16'hFFFF, 16'h0002, '0);
    chk(acc_a_out, 40'hFF_FFFF_FFFE);
    {sa, sb} = 2'h0;
    run(MAC_MPY, 1'b1, 16'hFFFF, 16'h0002, '0);
    chk(acc_b_out, 40'h00_0001_FFFE);
    sa = 1'b1;
    run(MAC_MPY, 1'b0, 16'hFFFF, 16'hFFFF, '0);
    chk(acc_a_out, 40'hFF_FFFF_0001);
    sb = 1'b1;
    wr(REG_CORE_CTRL, 16'h0001);
    run(MAC_MPY, 1'b0, 16'h4000, 16'h4000, '0);
    chk(acc_a_out, 40'h00_2000_0000);
    run(MAC_MPY, 1'b0, 16'h8000, 16'h8000, '0);
    chk(acc_a_out, 40'h00_8000_0000);
    wr(REG_CORE_CTRL, 16'h0000);
    sb = 1'b0;
    run(MAC_IMUL, 1'b0, 16'hFFFF, 16'hFFFF, '0);
    @(posedge core_clk);
    #1;
    chk({wide, wreg}, 33'h1_FFFF_0001);
    {sa, bm} = 2'h1;
    run(MAC_IMUL, 1'b0, 16'h00FF, 16'h00FF, '0);
    @(posedge core_clk);
    #1;
    chk({wide, wreg, n_wb}, 41'h0_0000_FE01_02);
    {sa, sb, bm} = 3'h6;
    run(MAC_LOAD, 1'b1, '0, '0, 40'h00_0000_000A);
    run(MAC_MSC, 1'b1, 16'h0002, 16'h0003, '0);
    chk(acc_b_out, 40'h00_0000_0004);
    run(MAC_MAC, 1'b1, 16'hFFFF, 16'h0003, '0);
    run(MAC_ADD, 1'b1, '0, '0, 40'hFF_FFFF_FFFF);
    chk({acc_b_out, acc_a_out}, 80'h00_0000_0000_00_8000_0000);
    se = 1'b1;
    run(MAC_LOAD, 1'b0, '0, '0, 40'h00_0000_0001);
    chk(acc_a_out, 40'h00_0000_0010);
    se = 1'b0;
    wr(REG_TRAP_CTRL, 16'h0400);
    run(MAC_ADD, 1'b0, '0, '0, 40'h01_0000_0000);
    chk({status_flags, arith_trap}, 7'h23);
    rd(REG_STATUS, 16'h0011);
    wr(REG_IRQ_MASK, 16'h0001);
    rd(REG_IRQ_STAT, 16'h0001);
    chk(irq, 1'b1);
    wr(REG_IRQ_MASK, 16'h0000);
    rd(REG_ACCA_LO, 16'h0010);
    chk(irq, 1'b0);
    wr(REG_IRQ_MASK, 16'h0001);
    wr(REG_IRQ_STAT, 16'h000F);
    rd(REG_IRQ_STAT, 16'h0000);
    chk(irq, 1'b0);
    run(MAC_ADD, 1'b0, '0, '0, 40'hFF_0000_0000);
    chk(status_flags, 6'h00);
    wr(REG_CORE_CTRL, 16'h0080);
    run(MAC_LOAD, 1'b0, '0, '0, '0);
    run(MAC_ADD, 1'b0, '0, '0, 40'h01_0000_0000);
    chk({status_flags, acc_a_out}, 46'h24_00_7FFF_FFFF);
    run(MAC_ADD, 1'b0, '0, '0, 40'hFF_0000_0000);
    chk(acc_a_out, 40'hFF_8000_0000);
    wr(REG_STATUS, 16'h0000);
    chk(status_flags, 6'h00);
    wr(REG_CORE_CTRL, 16'h0050);
    run(MAC_LOAD, 1'b1, '0, '0, 40'h7F_FFFF_FFFF);
    chk(status_flags, 6'h12);
    run(MAC_ADD, 1'b1, '0, '0, 40'h00_0000_0001);
    chk({status_flags, acc_b_out}, 46'h28_7F_FFFF_FFFF);
    rd(REG_ACCB_HI, 16'hFFFF);
    end_of_test();
  end
endmodule // mac_datapath_tb
